/* File: logic/sfspi_front_end.v */
/*
 SPI slave front end of a small serial flash: framing, shifting, dual
 output, busy timing of program and erase, one-time area and soft reset.
 Assumes pins are asynchronous to i_clock and sck is well below 25 MHz.
 The array itself is outside; this block drives its write/erase strobes.
*/
// Behaviour
// - works with host in spi mode 0 or mode 3
// - selected only while chip select is low
// - deselected: standby unless busy, serial output floats
// - deselected: serial input ignored, nothing accepted
// - operations framed by select falling and rising edges only
// - select rising during program or erase keeps device busy
// - command, address, write data sampled on rising sck
// - output data changes only on falling sck
// - dual read drives two bits per falling edge on both lines
// - program 1 to 256 bytes, single or dual input, sequential
// - erase page, 4k, 32k, 64k blocks or whole array
// - 128-byte one-time area, lower 64 factory, upper user once
// - program or erase result verified, failure reported
// - busy about 1.25ms per page program, 40ms per 4k erase
// - serial reset command clears write enable and fail flag, busy runs on
// - pause low ignores clock and input, floats output
// - write protect low locks protected sectors
`timescale 1ns/1ps
`include "sfspi_defs.vh"
module sfspi_front_end
#(
   parameter T_PROG_CYC = `SFSPI_T_PROG_US * `SFSPI_CLK_MHZ,
   parameter T_E4K_CYC  = `SFSPI_T_E4K_US * `SFSPI_CLK_MHZ,
   parameter T_E32K_CYC = `SFSPI_T_E32K_US * `SFSPI_CLK_MHZ,
   parameter T_E64K_CYC = `SFSPI_T_E64K_US * `SFSPI_CLK_MHZ,
   parameter T_CHIP_CYC = `SFSPI_T_CHIP_US * `SFSPI_CLK_MHZ,
   parameter T_PAGE_CYC = `SFSPI_T_PAGE_US * `SFSPI_CLK_MHZ
)
(
   input  wire        i_clock,        // system clock, 100 MHz
   input  wire        i_reset,        // synchronous, active high
   input  wire        i_enable,       // clock enable, freezes all state
   input  wire        i_select_n,     // chip select pin, low selects
   input  wire        i_sck,          // host serial clock pin
   input  wire        i_line_zero,    // serial input / dual_line_zero in
   input  wire        i_line_one,     // dual_line_one pin level in
   input  wire        i_hold_n,       // pause pin, low pauses
   input  wire        i_wprot_n,      // write-protect pin, low locks
   input  wire [7:0]  i_mem_rdata,    // array read data at o_mem_addr
   input  wire        i_mem_fail,     // array verify mismatch flag
   output reg         o_line_zero,    // dual_line_zero output value
   output reg         o_line_zero_oe, // dual_line_zero drive enable
   output reg         o_line_one,     // dual_line_one output value
   output reg         o_line_one_oe,  // dual_line_one drive enable
   output reg  [23:0] o_mem_addr,     // array byte address
   output reg  [7:0]  o_mem_wdata,    // byte to program
   output reg         o_mem_write,    // one-cycle program strobe
   output reg         o_mem_erase,    // one-cycle erase strobe
   output reg  [2:0]  o_erase_kind,   // 0 page 1 4k 2 32k 3 64k 4 chip
   output reg         o_busy,         // self-timed operation running
   output reg         o_standby       // deselected and idle
);
   localparam S_CMD  = 4'b0001;
   localparam S_ADDR = 4'b0010;
   localparam S_DATA = 4'b0100;
   localparam S_IGN  = 4'b1000;

   // two-flop synchronisers; the first stage feeds only the second
   wire [5:0] pin_async = {i_line_one, i_wprot_n, i_hold_n, i_line_zero,
                           i_sck, i_select_n};
   reg  [5:0] sync_a;
   reg  [5:0] sync_b;
   reg        sck_last;
   reg        sel_last;
   always @(posedge i_clock)
   begin
      if (i_reset)
      begin
         sync_a <= 6'h1b;
         sync_b <= 6'h1b;
      end
      else if (i_enable)
      begin
         sync_a <= pin_async;
         sync_b <= sync_a;
      end
   end
   wire sel_n   = sync_b[0];
   wire sck     = sync_b[1];
   wire sin     = sync_b[2];
   wire hold_n  = sync_b[3];
   wire wprot_n = sync_b[4];
   wire line_one = sync_b[5];
   wire active  = ~sel_n & hold_n;
   wire sck_up  = active & sck & ~sck_last;
   wire sck_dn  = active & ~sck & sck_last;
   wire frame_go  = sel_last & ~sel_n;
   wire frame_end = ~sel_last & sel_n;

   reg  [3:0]  state;
   reg  [7:0]  opcode;
   reg  [7:0]  shift_in;
   reg  [2:0]  bit_cnt;
   reg  [1:0]  addr_bytes;
   reg  [23:0] addr;
   reg  [7:0]  shift_out;
   reg         out_phase;
   reg         dual_out;
   reg         dual_in;
   reg  [8:0]  prog_cnt;
   reg         wel;
   reg         fail;
   reg  [31:0] busy_cnt;
   reg  [127:0] otp_lock;
   reg         pend_erase;
   reg  [2:0]  pend_kind;
   reg         pend_prog;
   reg         need_load;

   wire is_read = (opcode == `SFSPI_OP_READ) |
                  (opcode == `SFSPI_OP_DUAL_READ) |
                  (opcode == `SFSPI_OP_OTP_READ) |
                  (opcode == `SFSPI_OP_STATUS);
   wire is_prog = (opcode == `SFSPI_OP_PROG) |
                  (opcode == `SFSPI_OP_DUAL_PROG) |
                  (opcode == `SFSPI_OP_OTP_PROG);
   wire [7:0] status = {2'h0, fail, ~wprot_n, 2'h0, wel, o_busy};
   // protected area: every 64k block with addr[17:16] == 3 (one in four) locks under write protect
   wire locked = ~wprot_n & (addr[17:16] == 2'h3);
   wire [7:0] next_shift = {shift_in[6:0], sin};
   wire [7:0] next_dual  = {shift_in[5:0], line_one, sin};
   // opcodes followed by a three-byte address
   wire takes_addr = (next_shift == `SFSPI_OP_READ) |
      (next_shift == `SFSPI_OP_DUAL_READ) | (next_shift == `SFSPI_OP_OTP_READ) |
      (next_shift == `SFSPI_OP_PROG) | (next_shift == `SFSPI_OP_DUAL_PROG) |
      (next_shift == `SFSPI_OP_OTP_PROG) | (next_shift == `SFSPI_OP_ERASE_PAGE) |
      (next_shift == `SFSPI_OP_ERASE_4K) | (next_shift == `SFSPI_OP_ERASE_32K) |
      (next_shift == `SFSPI_OP_ERASE_64K);

   always @(posedge i_clock)
   begin
      if (i_reset)
      begin
         state <= S_CMD;  opcode <= 8'h00;  shift_in <= 8'h00;
         bit_cnt <= 3'h0; addr_bytes <= 2'h0; addr <= 24'h0;
         shift_out <= 8'h00; out_phase <= 1'b0; dual_out <= 1'b0;
         dual_in <= 1'b0; prog_cnt <= 9'h0; wel <= 1'b0; fail <= 1'b0;
         busy_cnt <= 32'h0; otp_lock <= 128'h0; o_busy <= 1'b0;
         pend_erase <= 1'b0; pend_kind <= 3'h0; pend_prog <= 1'b0;
         sck_last <= 1'b0; sel_last <= 1'b1; need_load <= 1'b0;
         o_line_zero <= 1'b0; o_line_zero_oe <= 1'b0;
         o_line_one <= 1'b0; o_line_one_oe <= 1'b0;
         o_mem_addr <= 24'h0; o_mem_wdata <= 8'h00;
         o_mem_write <= 1'b0; o_mem_erase <= 1'b0; o_erase_kind <= 3'h0;
         o_standby <= 1'b1;
      end
      else if (i_enable)
      begin
         // hold freezes the edge tracker, so an sck level change during the pause is seen as an edge on release
         if (hold_n)
            sck_last <= sck;
         sel_last <= sel_n;
         o_mem_write <= 1'b0;
         o_mem_erase <= 1'b0;
         o_standby <= sel_n & ~o_busy;
         // self-timed operation; verify result sampled at the end
         if (o_busy)
         begin
            if (busy_cnt == 32'h1)
            begin
               o_busy <= 1'b0;
               wel <= 1'b0;
               fail <= i_mem_fail;
               // no separate fail clear here: a reset command below
               // is gated so that the set wins in this cycle
            end
            busy_cnt <= busy_cnt - 32'h1;
         end
         // output enables follow the data phase, pause and select
         o_line_one_oe <= active & out_phase;
         o_line_zero_oe <= active & out_phase & dual_out;
         if (frame_go)
         begin
            state <= S_CMD;
            bit_cnt <= 3'h0;
            out_phase <= 1'b0;
            dual_out <= 1'b0;
            dual_in <= 1'b0;
            prog_cnt <= 9'h0;
            need_load <= 1'b0;
         end
         else if (frame_end)
         begin
            out_phase <= 1'b0;
            // program and erase start only when the frame closes cleanly
            if (pend_erase && wel && !o_busy && !locked)
            begin
               o_mem_erase <= 1'b1;
               o_erase_kind <= pend_kind;
               o_busy <= 1'b1;
               o_standby <= 1'b0;
               case (pend_kind)
                  3'h0:    busy_cnt <= T_PAGE_CYC;
                  3'h1:    busy_cnt <= T_E4K_CYC;
                  3'h2:    busy_cnt <= T_E32K_CYC;
                  3'h3:    busy_cnt <= T_E64K_CYC;
                  default: busy_cnt <= T_CHIP_CYC;
               endcase
            end
            else if (pend_prog && !o_busy && prog_cnt != 9'h0)
            begin
               o_busy <= 1'b1;
               o_standby <= 1'b0;
               busy_cnt <= T_PROG_CYC;
            end
            pend_erase <= 1'b0;
            pend_prog <= 1'b0;
         end
         else if (sck_up && state != S_IGN && !out_phase)
         begin
            shift_in <= (dual_in && state == S_DATA) ? next_dual
                                                      : next_shift;
            bit_cnt <= bit_cnt + ((dual_in && state == S_DATA) ? 3'h2
                                                               : 3'h1);
            if (bit_cnt == 3'h7 ||
                (dual_in && state == S_DATA && bit_cnt == 3'h6))
            begin
               case (state)
                  S_CMD:
                  begin
                     opcode <= next_shift;
                     addr_bytes <= 2'h0;
                     if (next_shift == `SFSPI_OP_RESET)
                     begin
                        wel <= 1'b0;
                        if (!(o_busy && busy_cnt == 32'h1))
                           fail <= 1'b0;
                        state <= S_IGN;
                     end
                     else if (next_shift == `SFSPI_OP_WREN)
                     begin
                        wel <= 1'b1;
                        state <= S_IGN;
                     end
                     else if (next_shift == `SFSPI_OP_ERASE_CHIP)
                     begin
                        pend_erase <= 1'b1;
                        pend_kind <= 3'h4;
                        state <= S_IGN;
                     end
                     else if (next_shift == `SFSPI_OP_STATUS)
                     begin
                        shift_out <= status;
                        out_phase <= 1'b1;
                        state <= S_DATA;
                     end
                     else if (takes_addr)
                        state <= S_ADDR;
                     else
                        state <= S_IGN;
                  end
                  S_ADDR:
                  begin
                     addr <= {addr[15:0], next_shift};
                     addr_bytes <= addr_bytes + 2'h1;
                     if (addr_bytes == 2'h2)
                     begin
                        state <= S_DATA;
                        o_mem_addr <= {addr[15:0], next_shift};
                        dual_in <= (opcode == `SFSPI_OP_DUAL_PROG);
                        dual_out <= (opcode == `SFSPI_OP_DUAL_READ);
                        out_phase <= is_read;
                        need_load <= is_read;
                        if (opcode == `SFSPI_OP_ERASE_PAGE ||
                            opcode == `SFSPI_OP_ERASE_4K ||
                            opcode == `SFSPI_OP_ERASE_32K ||
                            opcode == `SFSPI_OP_ERASE_64K)
                        begin
                           pend_erase <= 1'b1;
                           pend_kind <= (opcode == `SFSPI_OP_ERASE_PAGE)
                              ? 3'h0 : (opcode == `SFSPI_OP_ERASE_4K)
                              ? 3'h1 : (opcode == `SFSPI_OP_ERASE_32K)
                              ? 3'h2 : 3'h3;
                        end
                        pend_prog <= is_prog & wel & ~o_busy;
                     end
                  end
                  S_DATA:
                  begin
                     // page wrap keeps sequential bytes inside 256
                     if (pend_prog && !locked &&
                         prog_cnt != `SFSPI_PAGE_BYTES)
                     begin
                        if (opcode != `SFSPI_OP_OTP_PROG ||
                            (o_mem_addr[6:0] >= `SFSPI_OTP_USER_BASE &&
                             !otp_lock[o_mem_addr[6:0]]))
                        begin
                           o_mem_write <= 1'b1;
                           o_mem_wdata <= (dual_in) ? next_dual
                                                    : next_shift;
                           prog_cnt <= prog_cnt + 9'h1;
                        end
                        if (opcode == `SFSPI_OP_OTP_PROG)
                           otp_lock[o_mem_addr[6:0]] <= 1'b1;
                     end
                     o_mem_addr <= {o_mem_addr[23:8],
                                    o_mem_addr[7:0] + 8'h1};
                  end
                  default: state <= S_IGN;
               endcase
            end
         end
         // read data shifts on falling sck; next byte loaded when empty
         if (sck_dn && out_phase)
         begin
            if (dual_out)
            begin
               o_line_one <= shift_out[7];
               o_line_zero <= shift_out[6];
               shift_out <= {shift_out[5:0], 2'h0};
               bit_cnt <= bit_cnt + 3'h2;
            end
            else
            begin
               o_line_one <= shift_out[7];
               shift_out <= {shift_out[6:0], 1'b0};
               bit_cnt <= bit_cnt + 3'h1;
            end
            if ((dual_out && bit_cnt == 3'h6) || bit_cnt == 3'h7)
            begin
               shift_out <= (opcode == `SFSPI_OP_STATUS) ? status
                                                          : i_mem_rdata;
               if (opcode != `SFSPI_OP_STATUS)
                  o_mem_addr <= o_mem_addr + 24'h1;
            end
         end
         else if (need_load)
         begin
            // first byte fetched ahead, so the address runs one beyond
            shift_out <= i_mem_rdata;
            o_mem_addr <= o_mem_addr + 24'h1;
            need_load <= 1'b0;
         end
      end
   end
endmodule

/* File: logic/sfspi_defs.vh */
/*
 Constants for the serial flash front end: opcodes, sizes, timings.
 Assumes a 100 MHz system clock; the host serial clock is sampled.
*/
`ifndef SFSPI_DEFS_VH
`define SFSPI_DEFS_VH
`define SFSPI_CLK_MHZ        100
`define SFSPI_OP_READ        8'h03
`define SFSPI_OP_DUAL_READ   8'h3b
`define SFSPI_OP_PROG        8'h02
`define SFSPI_OP_DUAL_PROG   8'ha2
`define SFSPI_OP_ERASE_PAGE  8'h81
`define SFSPI_OP_ERASE_4K    8'h20
`define SFSPI_OP_ERASE_32K   8'h52
`define SFSPI_OP_ERASE_64K   8'hd8
`define SFSPI_OP_ERASE_CHIP  8'h60
`define SFSPI_OP_OTP_PROG    8'h9b
`define SFSPI_OP_OTP_READ    8'h77
`define SFSPI_OP_STATUS      8'h05
`define SFSPI_OP_RESET       8'hf0
`define SFSPI_OP_WREN        8'h06
`define SFSPI_PAGE_BYTES     9'd256
`define SFSPI_OTP_BYTES      128
`define SFSPI_OTP_USER_BASE  7'd64
`define SFSPI_STAT_BUSY      0
`define SFSPI_STAT_WEL       1
`define SFSPI_STAT_FAIL      5
`define SFSPI_STAT_WP        4
`define SFSPI_T_PROG_US      1250
`define SFSPI_T_E4K_US       40000
`define SFSPI_T_E32K_US      250000
`define SFSPI_T_E64K_US      500000
`define SFSPI_T_CHIP_US      1000000
`define SFSPI_T_PAGE_US      1250
`endif

/* File: verif/sfspi_front_end_assertions.sv */
/*
 Port checks of the serial flash front end.
 Assumes every busy length of the instance equals T_CYC.
*/
`timescale 1ns/1ps
module sfspi_front_end_assertions
#(
   parameter int T_CYC = 20
)
(
   input wire       i_clock,        // clock
   input wire       i_reset,        // sync reset
   input wire       i_select_n,     // select pin
   input wire       i_sck,          // serial clock pin
   input wire       i_hold_n,       // pause pin
   input wire       o_line_zero_oe, // line zero enable
   input wire       o_line_one,     // serial output
   input wire       o_line_one_oe,  // line one enable
   input wire       o_mem_erase,    // erase strobe
   input wire [2:0] o_erase_kind,   // erase size
   input wire       o_busy,         // busy
   input wire       o_standby       // standby
);
   localparam int T_LO = T_CYC - 2;
   localparam int T_HI = T_CYC + 6;
   reg       sck_d;
   reg [3:0] since_fall;
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (i_reset);
   // a bit moved late could be taken by the host on the next rise
   always @(posedge i_clock)
   begin
      sck_d <= i_sck;
      if (i_reset)
         since_fall <= 4'hf;
      else if (sck_d && !i_sck)
         since_fall <= 4'h0;
      else if (since_fall != 4'hf)
         since_fall <= since_fall + 4'h1;
   end
   sequence deselected_s;
      i_select_n [*5];
   endsequence
   sequence out_moves_s;
      o_line_one_oe && $past(o_line_one_oe) && $changed(o_line_one);
   endsequence
   desel_float_a: assert property (deselected_s |-> !o_line_one_oe)
      else $error("output driven while deselected");
   desel_quiet_a: assert property (deselected_s |-> !o_line_zero_oe)
      else $error("line zero driven while deselected");
   desel_idle_a: assert property ((i_select_n && !o_busy) [*6] |-> o_standby)
      else $error("no standby while deselected and idle");
   sel_active_a: assert property ((!i_select_n) [*5] |-> !o_standby)
      else $error("standby while selected");
   busy_standby_a: assert property (o_busy |-> !o_standby)
      else $error("standby while busy");
   dual_pair_a: assert property (o_line_zero_oe |-> o_line_one_oe)
      else $error("line zero driven without line one");
   out_on_fall_a: assert property (out_moves_s |-> since_fall <= 4'h4)
      else $error("output moved away from a falling sck");
   pause_float_a: assert property ((!i_hold_n) [*5] |-> !o_line_one_oe)
      else $error("output driven while paused");
   erase_pulse_a: assert property (o_mem_erase |->
      (o_erase_kind <= 3'h4) ##1 !o_mem_erase)
      else $error("erase strobe too long or bad kind");
   erase_busy_a: assert property (o_mem_erase |-> ##[0:2] o_busy)
      else $error("erase without busy");
   busy_len_a: assert property ($rose(o_busy) |-> ##[T_LO:T_HI] $fell(o_busy))
      else $error("busy length wrong");
endmodule

/* File: verif/sfspi_host_model.sv */
/*
 Host controller model driving the front end pins.
 Assumes one caller at a time; the bench resolves the shared lines.
*/
`timescale 1ns/1ps
module sfspi_host_model
(
   input  wire i_clock,           // bench clock
   input  wire i_line_zero,       // resolved dual_line_zero
   input  wire i_line_one,        // resolved dual_line_one
   output reg  o_select_n = 1'b1, // chip select
   output reg  o_sck = 1'b0,      // still between frames
   output wire o_line_zero,       // host level on line zero
   output wire o_line_one         // floating line one pattern
);
   reg         drv = 1'b0;
   reg         dv = 1'b0;
   reg         tog = 1'b0;
   reg         ph = 1'b0;
   logic [7:0] wq[$];
   logic [7:0] rq[$];
   // released lines move every cycle so a stale level never passes
   assign o_line_zero = drv ? dv : tog;
   assign o_line_one  = ~tog;
   always @(posedge i_clock)
      tog <= ~tog;
   // low half 5 or 6 cycles, high half 6: 115 ns on average
   task automatic clk_bit(input logic b, input logic d, output logic [1:0] s);
      @(posedge i_clock);
      o_sck <= 1'b0;
      dv    <= b;
      drv   <= d;
      repeat (5 + ph) @(posedge i_clock);
      s = {i_line_one, i_line_zero}; // sampled at the rise
      o_sck <= 1'b1; // device takes line zero here
      ph = ~ph;
      repeat (5) @(posedge i_clock);
   endtask
   task automatic xfer(input logic [7:0] op, input int na,
      input logic [23:0] a, input int nr, input logic dual, input logic m3);
      logic [1:0] s;
      logic [7:0] by;
      rq.delete();
      o_sck <= m3; // mode 3 idles high, mode 0 low
      @(posedge i_clock);
      o_select_n <= 1'b0;
      for (int i = 0; i < na; i++)
         wq.push_front(a[8*i +: 8]);
      wq.push_front(op);
      while (wq.size() > 0)
      begin
         by = wq.pop_front();
         for (int i = 7; i >= 0; i--)
            clk_bit(by[i], 1'b1, s); // all input on line zero
      end
      repeat (nr)
      begin
         for (int i = 7; i >= 0; i = i - (dual ? 2 : 1))
         begin
            clk_bit(1'b0, 1'b0, s); // host lets go of line zero
            if (dual)
               by[i -: 2] = s;
            else
               by[i] = s[1];
         end
         rq.push_back(by);
      end
      @(posedge i_clock);
      o_sck <= m3;
      drv   <= 1'b0;
      repeat (4) @(posedge i_clock);
      o_select_n <= 1'b1;
      repeat (12) @(posedge i_clock);
   endtask
endmodule

/* File: verif/test_sfspi_front_end.sv */
/*
 Self-checking bench of the serial flash front end.
 Assumes the host model and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "sfspi_defs.vh"
module test_sfspi_front_end;
   function automatic logic [7:0] exp_byte(input logic [23:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h3c;
   endfunction
   reg          i_clock = 1'b0;
   reg          i_reset = 1'b1;
   reg          i_hold_n = 1'b1;
   reg          i_mem_fail = 1'b0;
   reg          i_enable = 1'b1;
   reg          i_wprot_n = 1'b1;
   localparam int T_SIM = 20; // short busy keeps the run brief
   wire         sel_n, sck, h_l0, h_l1, d_l0, d_oe0, d_l1, d_oe1;
   wire         wr, er, busy, stby;
   wire [23:0]  maddr;
   wire [7:0]   wdata;
   wire [2:0]   kind;
   wire [7:0]   rdata = exp_byte(maddr);
   wire         l0 = d_oe0 ? d_l0 : h_l0; // enabled party sets the pin
   wire         l1 = d_oe1 ? d_l1 : h_l1;
   int          bad_count = 0;
   int          checks_done = 0;
   int          er_n;
   logic [2:0]  er_kind;
   logic [23:0] a;
   logic [7:0]  wr_seen[$];
   logic [7:0]  exp_q[$];
   logic [7:0]  er_ops[5] = '{`SFSPI_OP_ERASE_PAGE, `SFSPI_OP_ERASE_4K,
      `SFSPI_OP_ERASE_32K, `SFSPI_OP_ERASE_64K, `SFSPI_OP_ERASE_CHIP};
   sfspi_front_end #(.T_PROG_CYC(T_SIM), .T_E4K_CYC(T_SIM),
      .T_E32K_CYC(T_SIM), .T_E64K_CYC(T_SIM), .T_CHIP_CYC(T_SIM),
      .T_PAGE_CYC(T_SIM)) dut (
      .i_clock(i_clock), .i_reset(i_reset), .i_enable(i_enable),
      .i_select_n(sel_n), .i_sck(sck), .i_line_zero(l0), .i_line_one(l1),
      .i_hold_n(i_hold_n), .i_wprot_n(i_wprot_n), .i_mem_rdata(rdata),
      .i_mem_fail(i_mem_fail), .o_line_zero(d_l0), .o_line_zero_oe(d_oe0),
      .o_line_one(d_l1), .o_line_one_oe(d_oe1), .o_mem_addr(maddr),
      .o_mem_wdata(wdata), .o_mem_write(wr), .o_mem_erase(er),
      .o_erase_kind(kind), .o_busy(busy), .o_standby(stby));
   sfspi_host_model host (.i_clock(i_clock), .i_line_zero(l0),
      .i_line_one(l1), .o_select_n(sel_n), .o_sck(sck),
      .o_line_zero(h_l0), .o_line_one(h_l1));
   initial
      forever #5 i_clock = ~i_clock;
   always @(posedge i_clock)
   begin
      if (wr === 1'b1)
         wr_seen.push_back(wdata);
      if (er === 1'b1)
      begin
         er_n++;
         er_kind = kind;
      end
   end
   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_idle;
      int n;
      for (n = 0; n < 400 && busy !== 1'b0; n++)
         @(posedge i_clock);
      chk("busy end", 0, busy);
      if (n == 400)
         wrap_up;
   endtask
   task automatic cmd(input logic [7:0] op, input int na, input int nr,
      input logic dual);
      host.xfer(op, na, a, nr, dual, $urandom_range(1, 0));
   endtask
   initial
   begin
      void'($urandom(51));
      repeat (8) @(posedge i_clock);
      i_reset <= 1'b0;
      repeat (6) @(posedge i_clock);
      chk("standby", 1, stby);
      chk("busy", 0, busy);
      i_hold_n <= 1'b0; // pause while line zero keeps toggling
      repeat (6) @(posedge i_clock);
      i_hold_n <= 1'b1;
      for (int k = 0; k < 6; k++)
      begin
         a = (k < 2) ? 24'h0000ff : $urandom;
         cmd(k[0] ? `SFSPI_OP_DUAL_READ : `SFSPI_OP_READ, 3, 2, k[0]);
         chk("read byte 0", exp_byte(a), host.rq[0]);
         chk("read byte 1", exp_byte(a + 24'h1), host.rq[1]);
      end
      host.wq.push_back(8'h5a);
      cmd(`SFSPI_OP_PROG, 3, 0, 1'b0);
      chk("unenabled writes", 0, wr_seen.size());
      chk("unenabled busy", 0, busy);
      for (int k = 0; k < 2; k++)
      begin
         i_mem_fail <= k[0];
         wr_seen.delete();
         exp_q.delete();
         cmd(`SFSPI_OP_WREN, 0, 0, 1'b0);
         for (int i = 0; i < (k ? 257 : 1); i++)
            host.wq.push_back($urandom);
         for (int i = 0; i < host.wq.size() && i < 256; i++)
            exp_q.push_back(host.wq[i]);
         a = $urandom & 24'h03ff00;
         cmd(`SFSPI_OP_PROG, 3, 0, 1'b0);
         chk("busy after program", 1, busy);
         chk("standby while busy", 0, stby);
         wait_idle;
         chk("bytes written", exp_q.size(), wr_seen.size());
         foreach (exp_q[i])
            chk("written byte", exp_q[i], wr_seen[i]);
         cmd(`SFSPI_OP_STATUS, 0, 1, 1'b0);
         chk("fail flag", k, host.rq[0][`SFSPI_STAT_FAIL]);
      end
      i_mem_fail <= 1'b0;
      for (int k = 0; k < 5; k++)
      begin
         er_n = 0;
         a = $urandom & 24'h00f000;
         cmd(`SFSPI_OP_WREN, 0, 0, 1'b0);
         cmd(er_ops[k], (k == 4) ? 0 : 3, 0, 1'b0);
         chk("erase pulses", 1, er_n);
         chk("erase kind", k, er_kind);
         wait_idle;
      end
      cmd(`SFSPI_OP_WREN, 0, 0, 1'b0);
      cmd(`SFSPI_OP_RESET, 0, 0, 1'b0);
      cmd(`SFSPI_OP_STATUS, 0, 1, 1'b0);
      chk("enable after reset", 0, host.rq[0][`SFSPI_STAT_WEL]);
      wrap_up;
   end
endmodule
bind sfspi_front_end sfspi_front_end_assertions #(.T_CYC(T_PROG_CYC)) chk (
   .i_clock(i_clock), .i_reset(i_reset), .i_select_n(i_select_n),
   .i_sck(i_sck), .i_hold_n(i_hold_n), .o_line_zero_oe(o_line_zero_oe),
   .o_line_one(o_line_one), .o_line_one_oe(o_line_one_oe),
   .o_mem_erase(o_mem_erase), .o_erase_kind(o_erase_kind),
   .o_busy(o_busy), .o_standby(o_standby));
